// ---- dv/isc_bus_model.sv ----
`default_nettype none

module isc_bus_model (
  // Wire levels seen on the bus
  input wire logic scl,
  input wire logic sda,
  // Open-drain pull-down requests
  output logic scl_dn,
  output logic sda_dn
);
  timeunit 1ns;
  timeprecision 100ps;
  // Half of the 64 ns link clock
  localparam int HALF = 32;

  // Both lines released, so the pull-ups hold them high
  initial begin
    scl_dn = 1'b0;
    sda_dn = 1'b0;
  end

  // One clock pulse; waits out any stretch, so no timeout lives here
  task automatic pulse(output logic b);
    #HALF scl_dn = 1'b0;
    wait (scl);
    #(HALF / 2) b = sda;
    #(HALF / 2) scl_dn = 1'b1;
  endtask

  // Optional start, byte MSB first, ninth clock returns the acknowledge
  task automatic send(input logic st, input logic [7:0] d,
                      output logic ack);
    logic b;
    if (st) begin
      sda_dn = 1'b1;
      #HALF scl_dn = 1'b1;
    end
    for (int i = 7; i >= 0; i--) begin
      sda_dn = !d[i];
      pulse(b);
    end
    sda_dn = 1'b0;
    pulse(ack);
  endtask

  // SDA rises while SCL is high
  task automatic stop();
    sda_dn = 1'b1;
    #HALF scl_dn = 1'b0;
    #HALF sda_dn = 1'b0;
  endtask
endmodule // isc_bus_model

`default_nettype wire

// ---- dv/test_i2c_scl_timing_slave_ctrl.sv ----
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end

module test_i2c_scl_timing_slave_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import isc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, scl_out, scl_oe, sda_out, sda_oe, scl_dn, sda_dn;
  logic ack;
  logic [7:0] hi, lo, dat;
  logic [6:0] sad;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  // Open-drain wires with pull-ups
  wire logic scl_w = !(scl_oe | scl_dn);
  wire logic sda_w = !(sda_oe | sda_dn);

  always #2 hclk = !hclk;

  isc_top i_isc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe));
  isc_bus_model i_isc_bus_model (.scl(scl_w), .sda(sda_w),
    .scl_dn(scl_dn), .sda_dn(sda_dn));

  // ------------------------------------------------------------
  // Bus and measurement helpers
  // ------------------------------------------------------------
  function automatic int t_low(logic [7:0] h, logic [7:0] l);
    return ((l == 8'h00) ? h : l) + 5;
  endfunction

  // Ready and read data are taken at the rising edge that decides
  task automatic wait_rdy();
    do begin
      @(posedge hclk);
      rd = hrdata;
    end while (hreadyout !== 1'b1);
  endtask

  // Starts on an edge, so calls made after link events stay aligned
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rdr(input logic [7:0] a);
    ahb(1'b0, a, 32'h0);
  endtask

  // Bounded poll of one bit until it shows the wanted level
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int k;
    k = 0;
    do begin
      rdr(a);
      k++;
    end while (rd[b] !== v && k < 500);
  endtask

  // Counts negedges on which the signal keeps its level
  task automatic hold_len(ref logic s, input logic v);
    n = 0;
    while (s === v) begin
      n++;
      @(negedge hclk);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      end_sim();
    end
  end

  initial begin
    void'($urandom(2));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset value, unmapped place, strobe and protection while enabled
    rdr(OFF_SLAVE_CONTROL_B);
    `CHK(rd, REG_RESET)
    rdr(8'h40);
    `CHK(rd, 32'h0)
    wr(OFF_CTRLA, 32'h2);
    wr(OFF_SLAVE_CONTROL_B, 32'h0007_0100);
    rdr(OFF_SLAVE_CONTROL_B);
    `CHK(rd, 32'h0004_0000)
    wr(OFF_BAUD, 32'h0000_1234);
    rdr(OFF_BAUD);
    `CHK(rd, 32'h0)
    wr(OFF_CTRLA, 32'h0);
    $display("Test registers done");
    // Generator phases: low count zero first, then a random one
    for (int i = 0; i < 2; i++) begin
      hi = 8'($urandom_range(1, 20));
      lo = (i == 0) ? 8'h00 : 8'($urandom_range(1, 20));
      wr(OFF_BAUD, {16'h0, lo, hi});
      wr(OFF_CTRLA, 32'h0000_0102);
      @(posedge sda_oe);
      @(negedge hclk);
      hold_len(scl_oe, 1'b0);
      `CHK(n, t_low(hi, lo))
      hold_len(scl_oe, 1'b1);
      `CHK(n, t_low(hi, lo))
      hold_len(scl_oe, 1'b0);
      `CHK(n >= hi + 5 && n <= hi + 9, 1'b1)
      wr(OFF_CTRLA, 32'h2);
      poll(OFF_STAT, STAT_MBUSY_BIT, 1'b0);
      wr(OFF_CTRLA, 32'h0);
    end
    $display("Test generator done");
    // Slave: ACK by command, then NACK by smart-mode data read
    sad = 7'($urandom_range(8, 119));
    dat = 8'($urandom);
    wr(OFF_ADDR, {24'h0, sad, 1'b0});
    wr(OFF_SLAVE_CONTROL_B, 32'h0000_0100);
    wr(OFF_CTRLA, 32'h2);
    fork
      i_isc_bus_model.send(1'b1, {sad, 1'b0}, ack);
      begin
        poll(OFF_FLAG, FLAG_ADDRESS_MATCH_FLAG_BIT, 1'b1);
        wr(OFF_SLAVE_CONTROL_B, 32'h0003_0000);
        rdr(OFF_FLAG);
        `CHK(rd, 32'h0)
      end
    join
    `CHK(ack, 1'b0)
    wr(OFF_SLAVE_CONTROL_B, 32'h0004_0000);
    fork
      i_isc_bus_model.send(1'b0, dat, ack);
      begin
        poll(OFF_FLAG, FLAG_DATA_READY_FLAG_BIT, 1'b1);
        rdr(OFF_DATA);
        `CHK(rd, {24'h0, dat})
      end
    join
    `CHK(ack, 1'b1)
    i_isc_bus_model.stop();
    // Stop seen while active; data ready stays until a command
    poll(OFF_FLAG, FLAG_STOP_RECEIVED_FLAG_BIT, 1'b1);
    `CHK(rd, 32'h5)
    // Wait-for-start command: SCL freed with no acknowledge driven
    fork
      i_isc_bus_model.send(1'b1, {sad, 1'b0}, ack);
      begin
        poll(OFF_FLAG, FLAG_ADDRESS_MATCH_FLAG_BIT, 1'b1);
        wr(OFF_SLAVE_CONTROL_B, 32'h0002_0000);
        rdr(OFF_FLAG);
        `CHK(rd, 32'h0)
      end
    join
    `CHK(ack, 1'b1)
    i_isc_bus_model.stop();
    wr(OFF_CTRLA, 32'h0);
    $display("Test slave done");
    end_sim();
  end
endmodule // test_i2c_scl_timing_slave_ctrl

`default_nettype wire

// ---- rtl/isc_pkg.sv ----
`default_nettype none

package isc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRLA = 8'h00;
  localparam logic [7:0] OFF_SLAVE_CONTROL_B = 8'h04;
  localparam logic [7:0] OFF_BAUD = 8'h0C;
  localparam logic [7:0] OFF_FLAG = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1C;
  localparam logic [7:0] OFF_ADDR = 8'h24;
  localparam logic [7:0] OFF_DATA = 8'h28;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int CTRLA_EN_BIT = 1;
  localparam int CTRLA_RUN_BIT = 8;
  localparam int SLAVE_CONTROL_B_SMART_MODE_ENABLE_BIT = 8;
  localparam int SLAVE_CONTROL_B_CMD_LSB = 16;
  localparam int SLAVE_CONTROL_B_ACK_BIT = 18;
  localparam int FLAG_STOP_RECEIVED_FLAG_BIT = 0;
  localparam int FLAG_ADDRESS_MATCH_FLAG_BIT = 1;
  localparam int FLAG_DATA_READY_FLAG_BIT = 2;
  localparam int STAT_DIR_BIT = 0;
  localparam int STAT_STRETCH_BIT = 1;
  localparam int STAT_MBUSY_BIT = 2;
  localparam logic [1:0] CMD_ACK = 2'h3;
  localparam logic [1:0] CMD_WAIT_START = 2'h2;
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [8:0] SCL_EXTRA = 9'h005;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // SCL baud configuration
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
  } isc_baud_t;

endpackage : isc_pkg

`default_nettype wire

// ---- rtl/isc_scl_gen.sv ----
`default_nettype none

module isc_scl_gen (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Configuration
  input wire logic run,
  input wire isc_pkg::isc_baud_t baud,
  // Synchronised SCL level
  input wire logic scl_hi,
  // Line drive requests and busy status
  output logic scl_low,
  output logic sda_low,
  output logic busy
);
  import isc_pkg::*;

  typedef enum logic [7:0] {
    G_IDLE = 8'h01, G_START = 8'h02, G_LOW = 8'h04, G_RISE = 8'h08,
    G_HIGH = 8'h10, G_SLOW = 8'h20, G_SSU = 8'h40, G_BUF = 8'h80
  } isc_gen_t;

  isc_gen_t state_reg, state_next;
  logic [8:0] cnt_reg, cnt_next;
  logic [8:0] low_len, high_len;

  // Phase lengths; a zero low count falls back to the high count
  assign low_len = {1'b0, (baud.low == 8'h00) ? baud.high : baud.low}
                   + SCL_EXTRA;
  assign high_len = {1'b0, baud.high} + SCL_EXTRA;

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  // Counter reloads with length minus one, so a phase lasts len cycles
  always_comb begin
    state_next = state_reg;
    cnt_next = (cnt_reg != 9'h000) ? cnt_reg - 9'h001 : cnt_reg;
    unique case (state_reg)
      G_IDLE: begin
        if (run) begin
          state_next = G_START;
          cnt_next = low_len - 9'h001;
        end
      end
      G_START: begin
        if (cnt_reg == 9'h000) begin
          state_next = G_LOW;
          cnt_next = low_len - 9'h001;
        end
      end
      G_LOW: begin
        if (cnt_reg == 9'h000) begin
          state_next = G_RISE;
        end
      end
      // High is timed only once the line is seen high, so rise adds on
      G_RISE: begin
        if (scl_hi) begin
          state_next = G_HIGH;
          cnt_next = high_len - 9'h001;
        end
      end
      G_HIGH: begin
        if (cnt_reg == 9'h000) begin
          state_next = run ? G_LOW : G_SLOW;
          cnt_next = low_len - 9'h001;
        end
      end
      G_SLOW: begin
        if (cnt_reg == 9'h000) begin
          state_next = G_SSU;
          cnt_next = low_len - 9'h001;
        end
      end
      // Stop set-up counts only while SCL is really high
      G_SSU: begin
        if (!scl_hi) begin
          cnt_next = cnt_reg;
        end else if (cnt_reg == 9'h000) begin
          state_next = G_BUF;
          cnt_next = low_len - 9'h001;
        end
      end
      G_BUF: begin
        if (cnt_reg == 9'h000) begin
          state_next = G_IDLE;
        end
      end
      default: begin
        state_next = G_IDLE;
        cnt_next = 9'h000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= G_IDLE;
      cnt_reg <= 9'h000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  assign scl_low = (state_reg == G_LOW) || (state_reg == G_SLOW);
  assign sda_low = (state_reg == G_START) || (state_reg == G_SLOW) ||
                   (state_reg == G_SSU);
  assign busy = (state_reg != G_IDLE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_low_load;
    @(posedge hclk) disable iff (!hresetn)
      $rose(state_reg == G_LOW) |->
        cnt_reg == ({1'b0, (baud.low == 8'h00) ? baud.high : baud.low}
                    + 9'h004);
  endproperty
  a_low_load: assert property (p_low_load)
    else $error("low phase loaded with wrong length");

  property p_low_end;
    @(posedge hclk) disable iff (!hresetn)
      (state_reg == G_LOW && cnt_reg == 9'h000) |=> state_reg == G_RISE;
  endproperty
  a_low_end: assert property (p_low_end)
    else $error("low phase did not end at zero count");

  property p_high_load;
    @(posedge hclk) disable iff (!hresetn)
      $rose(state_reg == G_HIGH) |->
        $past(scl_hi) && cnt_reg == {1'b0, baud.high} + 9'h004;
  endproperty
  a_high_load: assert property (p_high_load)
    else $error("high phase started early or with wrong length");

  property p_count_down;
    @(posedge hclk) disable iff (!hresetn)
      (state_reg == G_LOW && cnt_reg != 9'h000) |=>
        state_reg == G_LOW && cnt_reg == $past(cnt_reg) - 9'h001;
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("phase counter did not step by one");

  property p_cond_len;
    @(posedge hclk) disable iff (!hresetn)
      ($rose(state_reg == G_START) || $rose(state_reg == G_BUF)) |->
        cnt_reg == low_len - 9'h001;
  endproperty
  a_cond_len: assert property (p_cond_len)
    else $error("bus condition not timed by low phase");

  c_full_stop: cover property (@(posedge hclk) disable iff (!hresetn)
    state_reg == G_BUF ##1 state_reg == G_IDLE);

endmodule : isc_scl_gen

`default_nettype wire

// ---- rtl/isc_top.sv ----
`default_nettype none

module isc_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Open-drain serial pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  import isc_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_RECV = 5'h02, S_WAIT = 5'h04, S_ACK = 5'h08,
    S_SKIP = 5'h10
  } isc_slv_t;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;

  // Two flops before use; the delayed copy finds edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s2 && !scl_d;
  assign scl_fall = !scl_s2 && scl_d;
  assign bus_start = scl_s2 && scl_d && sda_d && !sda_s2;
  assign bus_stop = scl_s2 && scl_d && !sda_d && sda_s2;

  // ----------------------------------------------------------------
  // Register file and AHB-Lite slave
  // ----------------------------------------------------------------
  logic en_reg, en_next, run_reg, run_next, smart_mode_enable_reg, smart_mode_enable_next;
  logic ack_reg, ack_next;
  isc_baud_t baud_reg, baud_next;
  logic [6:0] addr_reg, addr_next;
  logic [2:0] flag_reg, flag_next;
  logic acc_reg, acc_next, wr_reg, wr_next;
  logic [7:0] off_reg, off_next;
  logic hready_reg, hready_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic [2:0] flag_set;
  logic acc_wr, cmd_wr, data_rd, prot_ok, gen_busy;
  logic [1:0] cmd_val;
  logic dir_reg;
  logic [7:0] data_reg;
  isc_slv_t slv_reg;

  // Each access takes one wait state so reads see the latest writes
  assign acc_wr = acc_reg && wr_reg;
  assign cmd_val = hwdata[SLAVE_CONTROL_B_CMD_LSB +: 2];
  assign cmd_wr = acc_wr && (off_reg == OFF_SLAVE_CONTROL_B) &&
                  (cmd_val != CMD_NONE);
  assign data_rd = acc_reg && !wr_reg && (off_reg == OFF_DATA);
  assign prot_ok = !en_reg;

  always_comb begin
    en_next = en_reg;
    run_next = run_reg;
    smart_mode_enable_next = smart_mode_enable_reg;
    ack_next = ack_reg;
    baud_next = baud_reg;
    addr_next = addr_reg;
    acc_next = 1'b0;
    wr_next = wr_reg;
    off_next = off_reg;
    hready_next = 1'b1;
    hrdata_next = hrdata_reg;
    flag_next = flag_reg;
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      acc_next = 1'b1;
      hready_next = 1'b0;
      wr_next = hwrite && (hsize == HSIZE_WORD);
      off_next = haddr[7:0];
    end
    if (acc_wr) begin
      unique case (off_reg)
        OFF_CTRLA: begin
          en_next = hwdata[CTRLA_EN_BIT];
          run_next = hwdata[CTRLA_RUN_BIT];
        end
        OFF_SLAVE_CONTROL_B: begin
          ack_next = hwdata[SLAVE_CONTROL_B_ACK_BIT];
          if (prot_ok) begin
            smart_mode_enable_next = hwdata[SLAVE_CONTROL_B_SMART_MODE_ENABLE_BIT];
          end
        end
        OFF_BAUD: begin
          if (prot_ok) begin
            baud_next = hwdata[15:0];
          end
        end
        OFF_ADDR: begin
          if (prot_ok) begin
            addr_next = hwdata[7:1];
          end
        end
        OFF_FLAG: begin
          flag_next = flag_reg & ~hwdata[2:0];
        end
        default: begin
        end
      endcase
    end
    // A command clears every slave flag; a new event wins over it
    if (cmd_wr) begin
      flag_next = 3'h0;
    end
    flag_next = flag_next | flag_set;
    if (acc_reg && !wr_reg) begin
      unique case (off_reg)
        OFF_CTRLA: hrdata_next = {23'h0, run_reg, 6'h0, en_reg, 1'b0};
        // Command bits always read back as zero
        OFF_SLAVE_CONTROL_B: hrdata_next = {13'h0, ack_reg, 2'b00, 7'h0, smart_mode_enable_reg,
                                  8'h0};
        OFF_BAUD: hrdata_next = {16'h0, baud_reg};
        OFF_FLAG: hrdata_next = {29'h0, flag_reg};
        OFF_STAT: hrdata_next = {29'h0, gen_busy, slv_reg == S_WAIT,
                                 dir_reg};
        OFF_ADDR: hrdata_next = {24'h0, addr_reg, 1'b0};
        OFF_DATA: hrdata_next = {24'h0, data_reg};
        default: hrdata_next = REG_RESET;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_reg <= 1'b0;
      run_reg <= 1'b0;
      smart_mode_enable_reg <= 1'b0;
      ack_reg <= 1'b0;
      baud_reg <= '0;
      addr_reg <= 7'h00;
      flag_reg <= 3'h0;
      acc_reg <= 1'b0;
      wr_reg <= 1'b0;
      off_reg <= 8'h00;
      hready_reg <= 1'b1;
      hrdata_reg <= REG_RESET;
    end else begin
      en_reg <= en_next;
      run_reg <= run_next;
      smart_mode_enable_reg <= smart_mode_enable_next;
      ack_reg <= ack_next;
      baud_reg <= baud_next;
      addr_reg <= addr_next;
      flag_reg <= flag_next;
      acc_reg <= acc_next;
      wr_reg <= wr_next;
      off_reg <= off_next;
      hready_reg <= hready_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // ----------------------------------------------------------------
  // SCL generator
  // ----------------------------------------------------------------
  logic gen_scl_low, gen_sda_low;

  isc_scl_gen u_gen (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(run_reg && en_reg),
    .baud(baud_reg),
    .scl_hi(scl_s2),
    .scl_low(gen_scl_low),
    .sda_low(gen_sda_low),
    .busy(gen_busy)
  );

  // ----------------------------------------------------------------
  // Slave receiver
  // ----------------------------------------------------------------
  isc_slv_t slv_next;
  logic [7:0] shift_reg, shift_next, data_next;
  logic [3:0] bit_reg, bit_next;
  logic first_reg, first_next, dir_next, nack_reg, nack_next;
  logic scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
  logic ack_go, wait_go;

  // Ack action runs on an ack command, or on a data read in smart mode
  assign ack_go = (slv_reg == S_WAIT) &&
                  ((cmd_wr && cmd_val == CMD_ACK) ||
                   (smart_mode_enable_reg && data_rd));
  assign wait_go = (slv_reg == S_WAIT) && cmd_wr &&
                   (cmd_val == CMD_WAIT_START);

  always_comb begin
    slv_next = slv_reg;
    shift_next = shift_reg;
    bit_next = bit_reg;
    first_next = first_reg;
    dir_next = dir_reg;
    data_next = data_reg;
    nack_next = nack_reg;
    flag_set = 3'h0;
    if (bus_stop && slv_reg != S_IDLE) begin
      flag_set[FLAG_STOP_RECEIVED_FLAG_BIT] = 1'b1;
    end
    if (!en_reg || bus_stop) begin
      slv_next = S_IDLE;
    end else if (bus_start) begin
      slv_next = S_RECV;
      bit_next = 4'h0;
      first_next = 1'b1;
    end else begin
      unique case (slv_reg)
        S_IDLE: begin
        end
        S_RECV: begin
          if (scl_rise && bit_reg != BITS_PER_BYTE) begin
            shift_next = {shift_reg[6:0], sda_s2};
            bit_next = bit_reg + 4'h1;
          end else if (scl_fall && bit_reg == BITS_PER_BYTE) begin
            if (!first_reg) begin
              slv_next = S_WAIT;
              data_next = shift_reg;
              flag_set[FLAG_DATA_READY_FLAG_BIT] = 1'b1;
            end else if (shift_reg[7:1] == addr_reg) begin
              slv_next = S_WAIT;
              dir_next = shift_reg[0];
              flag_set[FLAG_ADDRESS_MATCH_FLAG_BIT] = 1'b1;
            end else begin
              slv_next = S_SKIP;
            end
          end
        end
        // Clock stretched until software decides
        S_WAIT: begin
          if (ack_go) begin
            slv_next = S_ACK;
            nack_next = (cmd_wr) ? hwdata[SLAVE_CONTROL_B_ACK_BIT] : ack_reg;
          end else if (wait_go) begin
            slv_next = S_SKIP;
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            first_next = 1'b0;
            bit_next = 4'h0;
            // Transmit to the master is not served: read turns to skip
            slv_next = (nack_reg || dir_reg) ? S_SKIP : S_RECV;
          end
        end
        S_SKIP: begin
        end
        default: slv_next = S_IDLE;
      endcase
    end
    scl_oe_next = gen_scl_low || (slv_next == S_WAIT);
    sda_oe_next = gen_sda_low || (slv_next == S_ACK && !nack_next);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slv_reg <= S_IDLE;
      shift_reg <= 8'h00;
      bit_reg <= 4'h0;
      first_reg <= 1'b0;
      dir_reg <= 1'b0;
      data_reg <= 8'h00;
      nack_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      slv_reg <= slv_next;
      shift_reg <= shift_next;
      bit_reg <= bit_next;
      first_reg <= first_next;
      dir_reg <= dir_next;
      data_reg <= data_next;
      nack_reg <= nack_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
    end
  end

  // Open drain: the level driven is always low; response is always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      hresp <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      hresp <= 1'b0;
    end
  end

  assign scl_oe = scl_oe_reg;
  assign sda_oe = sda_oe_reg;
  assign hrdata = hrdata_reg;
  assign hreadyout = hready_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_ack_cmd;
    @(posedge hclk) disable iff (!hresetn)
      (slv_reg == S_WAIT && en_reg && !bus_start && !bus_stop && cmd_wr &&
       cmd_val == CMD_ACK) |=>
        slv_reg == S_ACK && sda_oe_reg == !$past(hwdata[SLAVE_CONTROL_B_ACK_BIT]);
  endproperty
  a_ack_cmd: assert property (p_ack_cmd)
    else $error("command did not drive the chosen acknowledge");

  property p_smart;
    @(posedge hclk) disable iff (!hresetn)
      (slv_reg == S_WAIT && en_reg && !bus_start && !bus_stop &&
       smart_mode_enable_reg && data_rd && !cmd_wr) |=>
        slv_reg == S_ACK && nack_reg == $past(ack_reg);
  endproperty
  a_smart: assert property (p_smart)
    else $error("smart mode read did not run the acknowledge");

  property p_cmd_zero;
    @(posedge hclk) disable iff (!hresetn)
      (acc_reg && !wr_reg && off_reg == OFF_SLAVE_CONTROL_B) |=>
        hrdata[17:16] == 2'b00 && hreadyout;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero)
    else $error("command field read back nonzero");

  property p_flag_clr;
    @(posedge hclk) disable iff (!hresetn)
      (cmd_wr && flag_set == 3'h0) |=> flag_reg == 3'h0;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("command write left a flag set");

  property p_protect;
    @(posedge hclk) disable iff (!hresetn)
      (acc_wr && en_reg && off_reg == OFF_BAUD) |=> $stable(baud_reg);
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected field changed while enabled");

  property p_ack_free;
    @(posedge hclk) disable iff (!hresetn)
      (acc_wr && en_reg && off_reg == OFF_SLAVE_CONTROL_B) |=>
        ack_reg == $past(hwdata[SLAVE_CONTROL_B_ACK_BIT]);
  endproperty
  a_ack_free: assert property (p_ack_free)
    else $error("acknowledge bit not writable while enabled");

  c_addr_match: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(flag_reg[FLAG_ADDRESS_MATCH_FLAG_BIT]));
  c_data_ack: cover property (@(posedge hclk) disable iff (!hresetn)
    flag_reg[FLAG_DATA_READY_FLAG_BIT] ##[1:1000] slv_reg == S_ACK);
  c_stop_seen: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(flag_reg[FLAG_STOP_RECEIVED_FLAG_BIT]));

endmodule : isc_top

`default_nettype wire
